// *** rtl/strap_cfg_pkg.sv ***
// constants for the reset strap configuration capture block
package strap_cfg_pkg;
    localparam logic [1:0] IFACE_MII = 2'h0;
    localparam logic [1:0] IFACE_RMII = 2'h1;
    localparam logic [1:0] IFACE_GMII = 2'h2;
    localparam logic [1:0] IFACE_RGMII = 2'h3;
    localparam logic [1:0] IFACE_DEFAULT = IFACE_RGMII;
    localparam logic ROLE_MAC = 1'b1;
    localparam logic REFOUT_DEFAULT = 1'b1;
    localparam logic CLKSRC_CRYSTAL = 1'b1;
    localparam logic GIG_DEFAULT = 1'b1;
    localparam logic SERIAL_SPI = 1'b0;
    localparam int RMII_CLK_BIT = 7;
    localparam int RGMII_V2_LSB = 3;
    localparam int CFG_REG_WIDTH = 8;
    localparam logic [7:0] CFG_REG_OFFSET = 8'h56;
    localparam int STRAP_COUNT = 8;
    localparam int CLK_HZ = 50_000_000;
    localparam int XTAL_HZ = 25_000_000;
    localparam int SYS_CLK_COUNT = 5;
    localparam int SYS_CLK_HZ [SYS_CLK_COUNT] = '{125_000_000, 83_000_000, 41_000_000, 25_000_000, 10_000_000};
    localparam int RMII_REF_HZ = 50_000_000;
    localparam int REFOUT_HZ = 25_000_000;
    localparam int REFOUT_HALF = CLK_HZ / (2 * REFOUT_HZ);
    localparam int TENM_HZ = 10_000_000;
    localparam int TENM_DIV = CLK_HZ / TENM_HZ;
    localparam int TENM_HIGH = TENM_DIV / 2;
    localparam int HELD_IFACE_LSB = 5;
    localparam int HELD_ROLE_BIT = 4;
    localparam int HELD_REFOUT_BIT = 3;
    localparam int HELD_CLKSRC_BIT = 2;
    localparam int HELD_GIG_BIT = 1;
    localparam int HELD_SERIAL_BIT = 0;
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_SAMPLE = 2'h1,
        ST_RUN = 2'h3
    } cap_state_t;
endpackage

// *** rtl/strap_sync.sv ***
// two flip-flop synchroniser for strap pin levels
`timescale 1ns/1ps
module strap_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    always_ff @(posedge clk) begin
        meta_ff <= din;
        sync_ff <= meta_ff;
    end
    assign dout = sync_ff;
endmodule // strap_sync

// *** rtl/reset_strap_config_capture.sv ***
// strap capture at reset and the resulting uplink mode settings
// Operation
// (RULE1) strap levels sampled during power-down reset and during warm reset
// (RULE2) strap pins are pulled inputs in reset, driven outputs afterwards
// (RULE3) two interface straps pick MII, RMII, GMII or RGMII; RGMII default
// (RULE4) in GMII or MII, role strap high means MAC, low means PHY
// (RULE5) PHY role turns CRS, COL outputs; MII PHY also both interface clocks
// (RULE6) RMII role high drives 50 MHz on receive clock; low expects external
// (RULE7) RMII clock choice by role strap or configuration register bit 7
// (RULE8) reference output strap high enables 25 MHz output; low disables it
// (RULE9) RMII normal mode: clock source strap picks crystal or transmit clock
// (RULE10) gigabit strap picks 1 Gbps or 10/100 for GMII/RGMII; register override
// (RULE11) serial bus strap low selects SPI, high selects MDC/MDIO
// (RULE12) host should use SPI to program RGMII v2.0 bits with RGMII uplink
// (RULE13) system clocks 125, 83, 41, 25, 10 MHz derived from crystal; only 25 and 10 MHz are made here, from CLK
// (RULE14) active-low hardware reset resets device; straps sampled meanwhile
// (RULE15) sampled straps latched at reset release and held until next reset
`timescale 1ns/1ps
module reset_strap_config_capture
    import strap_cfg_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic RST_N_PIN,
    input wire logic [1:0] UPLINK_IFACE_SEL_STRAPS_IN,
    input wire logic UPLINK_ROLE_STRAP_IN,
    input wire logic REFOUT_ENABLE_STRAP_IN,
    input wire logic CLOCK_SOURCE_STRAP_IN,
    input wire logic UPLINK_GIG_STRAP_IN,
    input wire logic SERIAL_BUS_SEL_STRAP_IN,
    input wire logic [STRAP_COUNT-1:0] STRAP_PIN_FUNC_OUT,
    output logic [STRAP_COUNT-1:0] STRAP_PIN_OUT,
    output logic [STRAP_COUNT-1:0] STRAP_PIN_OE,
    output logic [STRAP_COUNT-1:0] STRAP_PULLUP_EN,
    output logic [STRAP_COUNT-1:0] STRAP_PULLDOWN_EN,
    input wire logic [CFG_REG_WIDTH-1:0] CFG_REG_WDATA,
    input wire logic CFG_REG_WE,
    input wire logic GIG_SPEED_WDATA,
    input wire logic GIG_SPEED_WE,
    output logic [CFG_REG_WIDTH-1:0] CFG_REG_RDATA,
    output logic [1:0] RGMII_V2_MODE,
    output logic DEVICE_RESET,
    output logic CFG_VALID,
    output logic [1:0] UPLINK_IFACE,
    output logic UPLINK_MAC_ROLE,
    output logic CRS_COL_OE,
    output logic MII_CLOCKS_OE,
    output logic RMII_INTERNAL_CLK,
    output logic RMII_REF_CLK_OUT,
    output logic RMII_REF_CLK_OE,
    output logic REFOUT_CLK,
    output logic REFOUT_EN,
    output logic PLL_FROM_CRYSTAL,
    output logic UPLINK_GIG,
    output logic SERIAL_MDIO_MODE,
    output logic SYS_CLK_10M
);
    logic [STRAP_COUNT-1:0] straps_async;
    logic [STRAP_COUNT-1:0] straps_sync;
    logic rst_n_sync;
    assign straps_async = {RST_N_PIN, UPLINK_IFACE_SEL_STRAPS_IN, UPLINK_ROLE_STRAP_IN, REFOUT_ENABLE_STRAP_IN,
        CLOCK_SOURCE_STRAP_IN, UPLINK_GIG_STRAP_IN, SERIAL_BUS_SEL_STRAP_IN};

    // pins and reset pin cross into CLK before use
    strap_sync #(.WIDTH(STRAP_COUNT)) u_sync (
        .clk(CLK),
        .din(straps_async),
        .dout(straps_sync)
    );
    assign rst_n_sync = straps_sync[STRAP_COUNT-1];

    cap_state_t state_ff, nxt_state;
    logic [STRAP_COUNT-2:0] held_ff, nxt_held;
    logic [CFG_REG_WIDTH-1:0] cfg_ff, nxt_cfg;
    logic cfg_rmii_sel_ff, nxt_cfg_rmii_sel;
    logic gig_ovr_ff, nxt_gig_ovr;
    logic gig_val_ff, nxt_gig_val;

    always_comb begin
        nxt_state = state_ff;
        nxt_held = held_ff;
        nxt_cfg = cfg_ff;
        nxt_cfg_rmii_sel = cfg_rmii_sel_ff;
        nxt_gig_ovr = gig_ovr_ff;
        nxt_gig_val = gig_val_ff;
        case (state_ff)
            ST_RESET: begin
                if (!rst_n_sync) begin
                    nxt_state = ST_SAMPLE; // RULE14
                end
            end
            ST_SAMPLE: begin
                nxt_held = straps_sync[STRAP_COUNT-2:0]; // RULE1
                nxt_cfg_rmii_sel = 1'b0;
                nxt_gig_ovr = 1'b0;
                if (rst_n_sync) begin
                    nxt_state = ST_RUN; // RULE15
                end
            end
            ST_RUN: begin
                if (!rst_n_sync) begin
                    nxt_state = ST_SAMPLE; // RULE1
                end
                if (CFG_REG_WE) begin
                    nxt_cfg = CFG_REG_WDATA;
                    nxt_cfg_rmii_sel = 1'b1; // RULE7
                end
                if (GIG_SPEED_WE) begin
                    nxt_gig_ovr = 1'b1; // RULE10
                    nxt_gig_val = GIG_SPEED_WDATA;
                end
            end
            default: begin
                nxt_state = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff <= ST_RESET;
            held_ff <= {IFACE_DEFAULT, ROLE_MAC, REFOUT_DEFAULT, CLKSRC_CRYSTAL, GIG_DEFAULT, SERIAL_SPI};
            cfg_ff <= 8'h00;
            cfg_rmii_sel_ff <= 1'b0;
            gig_ovr_ff <= 1'b0;
            gig_val_ff <= GIG_DEFAULT;
        end else begin
            state_ff <= nxt_state;
            held_ff <= nxt_held; // RULE15
            cfg_ff <= nxt_cfg;
            cfg_rmii_sel_ff <= nxt_cfg_rmii_sel;
            gig_ovr_ff <= nxt_gig_ovr;
            gig_val_ff <= nxt_gig_val;
        end
    end

    logic run;
    logic rmii_int;
    assign run = (state_ff == ST_RUN);
    assign rmii_int = cfg_rmii_sel_ff ? cfg_ff[RMII_CLK_BIT] : held_ff[HELD_ROLE_BIT]; // RULE7

    // decoded settings, all from flip-flops
    logic [1:0] held_iface;
    logic held_role;
    logic [1:0] iface_ff, nxt_iface;
    logic mac_ff, crs_oe_ff, mii_oe_ff, rmii_int_ff, refen_ff, pll_xtal_ff, gig_ff, mdio_ff, valid_ff, devrst_ff;
    logic nxt_mac, nxt_crs_oe, nxt_mii_oe, nxt_rmii_int, nxt_refen, nxt_pll_xtal, nxt_gig, nxt_mdio, nxt_valid;
    logic nxt_devrst;
    assign held_iface = held_ff[HELD_IFACE_LSB+1:HELD_IFACE_LSB];
    assign held_role = held_ff[HELD_ROLE_BIT];
    always_comb begin
        nxt_iface = held_iface; // RULE3
        nxt_mac = held_role; // RULE4
        nxt_crs_oe = run && !held_role && (held_iface == IFACE_GMII || held_iface == IFACE_MII); // RULE5
        nxt_mii_oe = run && !held_role && (held_iface == IFACE_MII); // RULE5
        nxt_rmii_int = run && (held_iface == IFACE_RMII) && rmii_int; // RULE6
        nxt_refen = run && held_ff[HELD_REFOUT_BIT]; // RULE8
        nxt_pll_xtal = !((held_iface == IFACE_RMII) && !rmii_int && !held_ff[HELD_CLKSRC_BIT]); // RULE9
        nxt_gig = (held_iface == IFACE_GMII || held_iface == IFACE_RGMII)
            && (gig_ovr_ff ? gig_val_ff : held_ff[HELD_GIG_BIT]); // RULE10
        nxt_mdio = held_ff[HELD_SERIAL_BIT]; // RULE11
        nxt_valid = run;
        nxt_devrst = !run; // RULE14
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            iface_ff <= IFACE_DEFAULT;
            mac_ff <= ROLE_MAC;
            crs_oe_ff <= 1'b0;
            mii_oe_ff <= 1'b0;
            rmii_int_ff <= 1'b0;
            refen_ff <= 1'b0;
            pll_xtal_ff <= CLKSRC_CRYSTAL;
            gig_ff <= GIG_DEFAULT;
            mdio_ff <= 1'b0;
            valid_ff <= 1'b0;
            devrst_ff <= 1'b1;
        end else begin
            iface_ff <= nxt_iface;
            mac_ff <= nxt_mac;
            crs_oe_ff <= nxt_crs_oe;
            mii_oe_ff <= nxt_mii_oe;
            rmii_int_ff <= nxt_rmii_int;
            refen_ff <= nxt_refen;
            pll_xtal_ff <= nxt_pll_xtal;
            gig_ff <= nxt_gig;
            mdio_ff <= nxt_mdio;
            valid_ff <= nxt_valid;
            devrst_ff <= nxt_devrst;
        end
    end

    // clock outputs from the 50 MHz CLK; 25 MHz is CLK/2, 10 MHz is CLK/5 (two high, three low)
    logic refdiv_ff, nxt_refdiv;
    logic [2:0] tendiv_ff, nxt_tendiv;
    logic ten_ff, nxt_ten;
    always_comb begin
        nxt_refdiv = ~refdiv_ff;
        nxt_tendiv = tendiv_ff + 3'h1;
        if (tendiv_ff == 3'(TENM_DIV - 1)) begin
            nxt_tendiv = 3'h0;
        end
        nxt_ten = (nxt_tendiv < 3'(TENM_HIGH)); // RULE13
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            refdiv_ff <= 1'b0;
            tendiv_ff <= 3'h0;
            ten_ff <= 1'b0;
        end else begin
            refdiv_ff <= nxt_refdiv; // RULE13
            tendiv_ff <= nxt_tendiv;
            ten_ff <= nxt_ten;
        end
    end

    // strap pins: pulled inputs in reset, driven once running
    logic [STRAP_COUNT-1:0] pin_out_ff;
    always_ff @(posedge CLK) begin
        if (RST) begin
            pin_out_ff <= 8'h00;
        end else begin
            pin_out_ff <= STRAP_PIN_FUNC_OUT;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < STRAP_COUNT; gi++) begin : g_pin
            assign STRAP_PIN_OE[gi] = valid_ff; // RULE2
            assign STRAP_PULLUP_EN[gi] = !valid_ff && (gi != 0); // RULE2
            assign STRAP_PULLDOWN_EN[gi] = !valid_ff && (gi == 0); // RULE2
        end
    endgenerate
    assign STRAP_PIN_OUT = pin_out_ff;

    assign CFG_REG_RDATA = cfg_ff;
    assign RGMII_V2_MODE = cfg_ff[RGMII_V2_LSB+1:RGMII_V2_LSB]; // RULE12
    assign DEVICE_RESET = devrst_ff;
    assign CFG_VALID = valid_ff;
    assign UPLINK_IFACE = iface_ff;
    assign UPLINK_MAC_ROLE = mac_ff;
    assign CRS_COL_OE = crs_oe_ff;
    assign MII_CLOCKS_OE = mii_oe_ff;
    assign RMII_INTERNAL_CLK = rmii_int_ff;
    // 50 MHz reference is CLK itself, gated; enable changes while CLK is high
    assign RMII_REF_CLK_OUT = rmii_int_ff & CLK; // RULE6
    assign RMII_REF_CLK_OE = rmii_int_ff; // RULE6
    assign REFOUT_CLK = refen_ff & refdiv_ff; // RULE8
    assign REFOUT_EN = refen_ff;
    assign PLL_FROM_CRYSTAL = pll_xtal_ff;
    assign UPLINK_GIG = gig_ff;
    assign SERIAL_MDIO_MODE = mdio_ff; // RULE11
    assign SYS_CLK_10M = ten_ff;
endmodule // reset_strap_config_capture

// *** dv/strap_cap_properties.sv ***
// concurrent checks on the strap capture block ports
`timescale 1ns/1ps
module strap_cap_properties
    import strap_cfg_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic RST_N_PIN,
    input wire logic CFG_REG_WE,
    input wire logic [7:0] CFG_REG_WDATA,
    input wire logic [7:0] CFG_REG_RDATA,
    input wire logic [7:0] STRAP_PIN_OE,
    input wire logic [7:0] STRAP_PULLUP_EN,
    input wire logic [7:0] STRAP_PULLDOWN_EN,
    input wire logic [1:0] RGMII_V2_MODE,
    input wire logic DEVICE_RESET,
    input wire logic CFG_VALID,
    input wire logic [1:0] UPLINK_IFACE,
    input wire logic UPLINK_MAC_ROLE,
    input wire logic CRS_COL_OE,
    input wire logic MII_CLOCKS_OE,
    input wire logic UPLINK_GIG,
    input wire logic REFOUT_EN,
    input wire logic REFOUT_CLK
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_oe_follows_valid: assert property (STRAP_PIN_OE == {8{CFG_VALID}}) else $error("pin enable mismatch");
    a_pulls_off_run: assert property (CFG_VALID |-> (STRAP_PULLUP_EN | STRAP_PULLDOWN_EN) == 8'h00)
        else $error("pulls left on");
    a_reset_gives_default: assert property (@(posedge CLK) disable iff (1'b0) $fell(RST) |->
        UPLINK_IFACE == IFACE_DEFAULT && !CFG_VALID && DEVICE_RESET) else $error("bad reset values");
    a_pin_low_resamples: assert property ($fell(RST_N_PIN) |-> ##[1:5] !CFG_VALID) else $error("no resample");
    a_capture_held: assert property (CFG_VALID && $past(CFG_VALID) |-> $stable(UPLINK_IFACE)
        && $stable(UPLINK_MAC_ROLE) && $stable(REFOUT_EN)) else $error("capture moved");
    a_phy_crs_col: assert property (CFG_VALID && !UPLINK_IFACE[0] |-> CRS_COL_OE == !UPLINK_MAC_ROLE)
        else $error("crs col enable wrong");
    a_mii_clocks: assert property (CFG_VALID |-> MII_CLOCKS_OE == (UPLINK_IFACE == IFACE_MII && !UPLINK_MAC_ROLE))
        else $error("mii clock enable wrong");
    a_slow_no_gig: assert property (CFG_VALID && !UPLINK_IFACE[1] |-> !UPLINK_GIG) else $error("gig on slow");
    a_cfg_write_lands: assert property (CFG_VALID && CFG_REG_WE |=> CFG_REG_RDATA == $past(CFG_REG_WDATA))
        else $error("config write lost");
    a_v2_bits: assert property (CFG_VALID && CFG_REG_WE |=>
        RGMII_V2_MODE == $past(CFG_REG_WDATA[RGMII_V2_LSB+1:RGMII_V2_LSB])) else $error("v2 bits wrong");
    a_refout_quiet: assert property (!REFOUT_EN |-> !REFOUT_CLK) else $error("ref clock not gated");
    c_capture: cover property ($rose(CFG_VALID));
    c_cfg_write: cover property (CFG_VALID && CFG_REG_WE);
    c_mii_phy: cover property (MII_CLOCKS_OE);
endmodule // strap_cap_properties
bind reset_strap_config_capture strap_cap_properties i_strap_cap_properties (.CLK, .RST, .RST_N_PIN,
    .CFG_REG_WE, .CFG_REG_WDATA, .CFG_REG_RDATA, .STRAP_PIN_OE, .STRAP_PULLUP_EN, .STRAP_PULLDOWN_EN,
    .RGMII_V2_MODE, .DEVICE_RESET, .CFG_VALID, .UPLINK_IFACE, .UPLINK_MAC_ROLE, .CRS_COL_OE,
    .MII_CLOCKS_OE, .UPLINK_GIG, .REFOUT_EN, .REFOUT_CLK);

// *** dv/strap_board.sv ***
// board strap resistors sharing the pins with the device drivers
`timescale 1ns/1ps
module strap_board (
    input wire logic [6:0] res_lvl,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_out,
    output logic [1:0] iface,
    output logic role,
    output logic refout,
    output logic clksrc,
    output logic gig,
    output logic serial
);
    logic [6:0] lvl;
    // driven pins show the device value, released pins the resistor level
    assign lvl = (pin_oe[6:0] & pin_out[6:0]) | (~pin_oe[6:0] & res_lvl);
    assign {iface, role, refout, clksrc, gig, serial} = lvl;
endmodule // strap_board

// *** dv/tb.sv ***
// testbench for the strap capture block
`timescale 1ns/1ps
module tb;
    import strap_cfg_pkg::*;
    logic CLK, RST, RST_N_PIN, CFG_REG_WE, GIG_SPEED_WDATA, GIG_SPEED_WE;
    logic UPLINK_ROLE_STRAP_IN, REFOUT_ENABLE_STRAP_IN, CLOCK_SOURCE_STRAP_IN, UPLINK_GIG_STRAP_IN;
    logic SERIAL_BUS_SEL_STRAP_IN, DEVICE_RESET, CFG_VALID, UPLINK_MAC_ROLE, CRS_COL_OE, MII_CLOCKS_OE;
    logic RMII_INTERNAL_CLK, RMII_REF_CLK_OUT, RMII_REF_CLK_OE, REFOUT_CLK, REFOUT_EN, PLL_FROM_CRYSTAL;
    logic UPLINK_GIG, SERIAL_MDIO_MODE, SYS_CLK_10M;
    logic [1:0] UPLINK_IFACE_SEL_STRAPS_IN, RGMII_V2_MODE, UPLINK_IFACE;
    logic [7:0] STRAP_PIN_FUNC_OUT, STRAP_PIN_OUT, STRAP_PIN_OE, STRAP_PULLUP_EN, STRAP_PULLDOWN_EN;
    logic [7:0] CFG_REG_WDATA, CFG_REG_RDATA;
    logic [6:0] res_lvl;
    int fails, comparisons, cyc, n;
    int rises_ref, rises_rmii, rises_ten;
    logic [3:0] i;
    reset_strap_config_capture i_reset_strap_config_capture (.CLK, .RST, .RST_N_PIN, .UPLINK_IFACE_SEL_STRAPS_IN,
        .UPLINK_ROLE_STRAP_IN, .REFOUT_ENABLE_STRAP_IN, .CLOCK_SOURCE_STRAP_IN, .UPLINK_GIG_STRAP_IN,
        .SERIAL_BUS_SEL_STRAP_IN, .STRAP_PIN_FUNC_OUT, .STRAP_PIN_OUT, .STRAP_PIN_OE, .STRAP_PULLUP_EN,
        .STRAP_PULLDOWN_EN, .CFG_REG_WDATA, .CFG_REG_WE, .GIG_SPEED_WDATA, .GIG_SPEED_WE, .CFG_REG_RDATA,
        .RGMII_V2_MODE, .DEVICE_RESET, .CFG_VALID, .UPLINK_IFACE, .UPLINK_MAC_ROLE, .CRS_COL_OE, .MII_CLOCKS_OE,
        .RMII_INTERNAL_CLK, .RMII_REF_CLK_OUT, .RMII_REF_CLK_OE, .REFOUT_CLK, .REFOUT_EN, .PLL_FROM_CRYSTAL,
        .UPLINK_GIG, .SERIAL_MDIO_MODE, .SYS_CLK_10M);
    always @(posedge REFOUT_CLK) rises_ref++;
    always @(posedge RMII_REF_CLK_OUT) rises_rmii++;
    always @(posedge SYS_CLK_10M) rises_ten++;
    strap_board i_strap_board (.res_lvl, .pin_oe(STRAP_PIN_OE), .pin_out(STRAP_PIN_OUT),
        .iface(UPLINK_IFACE_SEL_STRAPS_IN), .role(UPLINK_ROLE_STRAP_IN), .refout(REFOUT_ENABLE_STRAP_IN),
        .clksrc(CLOCK_SOURCE_STRAP_IN), .gig(UPLINK_GIG_STRAP_IN), .serial(SERIAL_BUS_SEL_STRAP_IN));
    initial begin
        CLK = 0;
        forever #10 CLK = ~CLK;
    end
    task summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // resistor levels, hardware reset pulse, wait for valid
    task cap(input logic [6:0] lv);
        res_lvl = lv;
        RST_N_PIN = 0;
        repeat (6) @(negedge CLK);
        chk("pullup", STRAP_PULLUP_EN, 8'hfe);
        chk("pulldown", STRAP_PULLDOWN_EN, 8'h01);
        RST_N_PIN = 1;
        n = 0;
        while (CFG_VALID !== 1'b1 && n < 40) begin
            @(negedge CLK);
            n++;
        end
        @(negedge CLK);
    endtask
    // output clock rises over 100 cycles of CLK
    task rates(input logic [7:0] ref_e, input logic [7:0] rmii_e);
        {rises_ref, rises_rmii, rises_ten} = '0;
        repeat (100) @(negedge CLK);
        chk("refclk", 8'(rises_ref), ref_e);
        chk("rmiiref", 8'(rises_rmii), rmii_e);
        chk("tenclk", 8'(rises_ten), 8'h14);
    endtask
    task wr(input logic [7:0] d, input logic g, input logic gw);
        CFG_REG_WDATA = d;
        CFG_REG_WE = !gw;
        GIG_SPEED_WDATA = g;
        GIG_SPEED_WE = gw;
        @(negedge CLK);
        CFG_REG_WE = 0;
        GIG_SPEED_WE = 0;
        repeat (3) @(negedge CLK);
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        {RST, RST_N_PIN, CFG_REG_WE, GIG_SPEED_WE, GIG_SPEED_WDATA, CFG_REG_WDATA} = 13'h1800;
        {STRAP_PIN_FUNC_OUT, res_lvl, fails, comparisons, cyc} = '0;
        repeat (10) @(negedge CLK);
        RST = 0;
        chk("default", UPLINK_IFACE, IFACE_DEFAULT);
        for (i = 0; i < 8; i++) begin
            cap({i[1:0], i[2], i[0], i[1], ~i[0], i[2] ^ i[0]});
            chk("iface", UPLINK_IFACE, i[1:0]);
            if (!i[0]) chk("role", UPLINK_MAC_ROLE, i[2]);
            chk("crscol", CRS_COL_OE, !i[0] && !i[2]);
            chk("miiclk", MII_CLOCKS_OE, i[1:0] == 2'h0 && !i[2]);
            if (i[1:0] == 2'h1) chk("rmiiclk", RMII_INTERNAL_CLK, i[2]);
            if (i[1:0] == 2'h1) chk("rmiioe", RMII_REF_CLK_OE, i[2]);
            chk("pll", PLL_FROM_CRYSTAL, i != 4'h1);
            chk("gig", UPLINK_GIG, i[1] & ~i[0]);
            chk("refout", REFOUT_EN, i[0]);
            chk("mdio", SERIAL_MDIO_MODE, i[2] ^ i[0]);
            chk("devrst", DEVICE_RESET, 1'b0);
            chk("pinoe", STRAP_PIN_OE, 8'hff);
            rates(i[0] ? 8'h32 : 8'h00, (i[1:0] == 2'h1 && i[2]) ? 8'h64 : 8'h00);
            STRAP_PIN_FUNC_OUT = {4'ha, i} ^ 8'h55;
            repeat (4) @(negedge CLK);
            chk("pinout", STRAP_PIN_OUT, {4'ha, i} ^ 8'h55);
            chk("held", UPLINK_IFACE, i[1:0]);
        end
        wr(8'h00, 1'b1, 1'b1);
        chk("gigset", UPLINK_GIG, 1'b1);
        cap(7'h70);
        chk("gigclr", UPLINK_GIG, 1'b0);
        cap(7'h24);
        chk("pllxtal", PLL_FROM_CRYSTAL, 1'b1);
        chk("rmiiext", RMII_INTERNAL_CLK, 1'b0);
        cap(7'h33);
        wr(8'h18, 1'b0, 1'b0);
        chk("rdata", CFG_REG_RDATA, 8'h18);
        chk("v2", RGMII_V2_MODE, 2'h3);
        chk("regext", RMII_INTERNAL_CLK, 1'b0);
        wr(8'h80, 1'b0, 1'b0);
        chk("regint", RMII_INTERNAL_CLK, 1'b1);
        rates(8'h00, 8'h64);
        RST = 1;
        repeat (2) @(negedge CLK);
        RST = 0;
        chk("rstvalid", CFG_VALID, 1'b0);
        chk("rstdev", DEVICE_RESET, 1'b1);
        chk("rstiface", UPLINK_IFACE, IFACE_DEFAULT);
        summarize();
    end
endmodule // tb
